// ===== rtl/dts_device.sv
// Function
// - reset: dual-thread, profile groups 0-63/64-127
// - concurrency only across separate profile groups
// - single-thread host merges searches, one key
// - single-thread sub-searches use distinct partitions
// - dual mode picks two non-conflicting queue heads
// - four queues per port, steered by profile[6:5]
// - candidates: four heads one port, eight two
// - thread 0 bank 0, thread 1 bank 1
// - profile, key builder, compare memory split limits
// - superblock split gives each thread 2..62
// - keys 480b+ keep superblock pairs together; host does no superblock pair-trim, device flags odd split on bank_err_o
// - bank split restricts searches, not read/write
// - both banks issue in same cycle
// - search enables superblocks only in own bank
// - any superblock count within own bank
// - data segment split gives each thread 1..63
// - keys 320b+ keep segment pairs together; host pair-trims only above 320b
// - segment reads stay in bank, pairs if wide
// - any segment count within own bank
`timescale 1ns/1ps
`default_nettype none
`include "dts_params.svh"
module dts_device #(
  parameter int DEPTH = `DTS_QDEPTH
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  dts_if.dev link,
  input wire logic cfg_load_i,
  input wire logic cfg_dual_i,
  input wire logic cfg_two_port_i,
  input wire logic [6:0] cfg_prof_split_i,
  input wire logic [6:0] cfg_sb_split_i,
  input wire logic [6:0] cfg_seg_split_i,
  input wire logic [1:0] cfg_kb_split_i,
  input wire logic [3:0] cfg_cm_split_i,
  output logic [1:0] iss_valid_o,
  output dts_pkg::dts_instr_s iss0_instr_o,
  output dts_pkg::dts_instr_s iss1_instr_o,
  output logic bank_err_o,
  output logic cfg_err_o,
  output logic dual_mode_o,
  output logic [1:0] kb_split_o,
  output logic [3:0] cm_split_o
);
  localparam int IW = $bits(dts_pkg::dts_instr_s);
  localparam int CW = $clog2(DEPTH+1);

  // configuration registers
  logic dual_reg;
  logic two_port_reg;
  logic [6:0] prof_split_reg;
  logic [6:0] sb_split_reg;
  logic [6:0] seg_split_reg;
  logic [1:0] kb_split_reg;
  logic [3:0] cm_split_reg;
  logic cfg_err_reg;

  // scheduler state and issue registers
  logic [2:0] ptr_reg;
  logic [1:0] rdy_reg;
  logic [1:0] rdy_next;
  logic [1:0] iss_valid_reg;
  dts_pkg::dts_instr_s iss0_reg;
  dts_pkg::dts_instr_s iss1_reg;
  logic bank_err_reg;

  logic [7:0] head_v;
  logic [7:0] head_thr;
  logic [7:0] pop;
  logic [7:0] room;
  dts_pkg::dts_instr_s head [8];

  // boundary checks on a configuration load
  wire prof_ok = (cfg_prof_split_i[4:0] == 5'h00) && (cfg_prof_split_i >= `DTS_PROF_SPLIT_MIN)
                 && (cfg_prof_split_i <= `DTS_PROF_SPLIT_MAX);
  wire kb_ok = (cfg_kb_split_i >= `DTS_KB_SPLIT_MIN);
  wire cm_ok = (cfg_cm_split_i >= `DTS_CM_SPLIT_MIN);
  wire sb_ok = (cfg_sb_split_i >= `DTS_SB_SPLIT_MIN) && (cfg_sb_split_i <= `DTS_SB_SPLIT_MAX);
  wire seg_ok = (cfg_seg_split_i >= `DTS_SEG_SPLIT_MIN)
                && (cfg_seg_split_i <= `DTS_SEG_SPLIT_MAX);
  wire cfg_ok = prof_ok && kb_ok && cm_ok && sb_ok && seg_ok;

  // bank 0 membership masks
  wire [63:0] sb_bank0 = (64'h1 << sb_split_reg) - 64'h1;
  wire [63:0] seg_bank0 = (64'h1 << seg_split_reg) - 64'h1;

  // eight queues: port p, group g at index p*4+g
  genvar q;
  generate
    for (q = 0; q < 8; q++) begin : g_q
      logic [IW-1:0] raw;
      logic [CW-1:0] cnt;
      wire en = (q < 4) || two_port_reg;
      wire sel = (link.req_instr[q/4].profile[`DTS_QSEL_HI:`DTS_QSEL_LO] == 2'(q % 4));
      wire psh = en && sel && link.req_valid[q/4] && link.req_ready[q/4];
      dts_queue #(
        .W(IW),
        .DEPTH(DEPTH)
      ) u_q (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .push_i(psh),
        .push_data_i(link.req_instr[q/4]),
        .pop_i(pop[q]),
        .head_valid_o(head_v[q]),
        .head_data_o(raw),
        .count_o(cnt)
      );
      assign head[q] = dts_pkg::dts_instr_s'(raw);
      // thread by profile group; single-thread mode runs all on thread 0
      assign head_thr[q] = dual_reg && (head[q].profile >= prof_split_reg);
      assign room[q] = (cnt <= CW'(DEPTH - 2));
    end
  endgenerate

  // pick one head per thread, scanning from the rotating pointer
  logic pick0_v;
  logic pick1_v;
  logic first1;
  logic [2:0] pick0;
  logic [2:0] pick1;
  logic [2:0] scan;
  always_comb begin
    pick0_v = 1'b0;
    pick1_v = 1'b0;
    first1 = 1'b0;
    pick0 = 3'h0;
    pick1 = 3'h0;
    scan = 3'h0;
    for (int i = 0; i < 8; i++) begin
      scan = ptr_reg + 3'(i);
      if (head_v[scan] && (two_port_reg || !scan[2])) begin
        if (!head_thr[scan] && !pick0_v) begin
          pick0_v = 1'b1;
          pick0 = scan;
        end else if (head_thr[scan] && !pick1_v) begin
          pick1_v = 1'b1;
          pick1 = scan;
          first1 = !pick0_v;
        end
      end
    end
  end

  // resource overlap between the two candidates
  wire overlap = |(head[pick0].sb_mask & head[pick1].sb_mask)
                 || |(head[pick0].seg_mask & head[pick1].seg_mask);
  wire conflict = pick0_v && pick1_v && overlap;
  wire go0 = pick0_v && !(conflict && first1);
  wire go1 = pick1_v && !(conflict && !first1);

  // bank crossings of issued searches; reads and writes never pass here
  wire cross0 = dual_reg && (|(head[pick0].sb_mask & ~sb_bank0)
                || |(head[pick0].seg_mask & ~seg_bank0));
  wire cross1 = |(head[pick1].sb_mask & sb_bank0)
                || |(head[pick1].seg_mask & seg_bank0);
  wire pair0 = dual_reg && (((head[pick0].key_width >= `DTS_SB_PAIR_KEY) && sb_split_reg[0])
               || ((head[pick0].key_width >= `DTS_SEG_PAIR_KEY) && seg_split_reg[0]));
  wire pair1 = ((head[pick1].key_width >= `DTS_SB_PAIR_KEY) && sb_split_reg[0])
               || ((head[pick1].key_width >= `DTS_SEG_PAIR_KEY) && seg_split_reg[0]);
  wire err_next = (go0 && (cross0 || pair0)) || (go1 && (cross1 || pair1));

  assign pop = (go0 ? (8'h01 << pick0) : 8'h00) | (go1 ? (8'h01 << pick1) : 8'h00);
  assign rdy_next = {&room[7:4] && two_port_reg, &room[3:0]};

  // configuration, reset into dual-thread mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dual_reg <= 1'b1;
      two_port_reg <= 1'b0;
      prof_split_reg <= `DTS_RST_PROF_SPLIT;
      sb_split_reg <= `DTS_RST_SB_SPLIT;
      seg_split_reg <= `DTS_RST_SEG_SPLIT;
      kb_split_reg <= `DTS_RST_KB_SPLIT;
      cm_split_reg <= `DTS_RST_CM_SPLIT;
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_err_reg <= cfg_load_i && !cfg_ok;
      if (cfg_load_i && cfg_ok) begin
        dual_reg <= cfg_dual_i;
        two_port_reg <= cfg_two_port_i;
        prof_split_reg <= cfg_prof_split_i;
        sb_split_reg <= cfg_sb_split_i;
        seg_split_reg <= cfg_seg_split_i;
        kb_split_reg <= cfg_kb_split_i;
        cm_split_reg <= cfg_cm_split_i;
      end
    end
  end

  // issue both banks together; any block count passes unchecked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ptr_reg <= 3'h0;
      rdy_reg <= 2'b00;
      iss_valid_reg <= 2'b00;
      iss0_reg <= '0;
      iss1_reg <= '0;
      bank_err_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_reg + 3'((go0 || go1) ? 1 : 0);
      rdy_reg <= rdy_next;
      iss_valid_reg <= {go1, go0};
      iss0_reg <= head[pick0];
      iss1_reg <= head[pick1];
      bank_err_reg <= err_next;
    end
  end

  assign link.req_ready = rdy_reg;
  assign iss_valid_o = iss_valid_reg;
  assign iss0_instr_o = iss0_reg;
  assign iss1_instr_o = iss1_reg;
  assign bank_err_o = bank_err_reg;
  assign cfg_err_o = cfg_err_reg;
  assign dual_mode_o = dual_reg;
  assign kb_split_o = kb_split_reg;
  assign cm_split_o = cm_split_reg;
endmodule
`default_nettype wire

// ===== rtl/dts_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "dts_params.svh"
module dts_host (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  dts_if.host link,
  input wire logic dual_thread_mode_i,
  input wire logic [6:0] prof_split_i,
  input wire logic [6:0] sb_split_i,
  input wire logic [6:0] seg_split_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_port_i,
  input wire dts_pkg::dts_instr_s cmd_instr_i,
  output logic cmd_ready_o,
  output logic reject_o
);
  dts_pkg::dts_host_state_e state_reg;
  dts_pkg::dts_instr_s instr_reg;
  logic [1:0] valid_reg;
  logic cmd_ready_reg;
  logic reject_reg;

  // duplicate partition among the used sub-searches
  logic dup;
  always_comb begin
    dup = 1'b0;
    for (int a = 0; a < 4; a++) begin
      for (int b = a + 1; b < 4; b++) begin
        if ((3'(b) < cmd_instr_i.n_srch) && (cmd_instr_i.part[a] == cmd_instr_i.part[b])) begin
          dup = 1'b1;
        end
      end
    end
  end

  // own-bank masks, segment mask pair-trimmed for wide keys
  wire thr1 = cmd_instr_i.profile >= prof_split_i;
  wire [63:0] sb_b0 = (64'h1 << sb_split_i) - 64'h1;
  wire [63:0] seg_b0 = (64'h1 << seg_split_i) - 64'h1;
  wire [63:0] sb_keep = thr1 ? ~sb_b0 : sb_b0;
  wire [63:0] seg_keep = thr1 ? ~seg_b0 : seg_b0;
  logic [63:0] seg_pair;
  always_comb begin
    seg_pair = seg_keep;
    for (int i = 0; i < 64; i++) begin
      seg_pair[i] = seg_keep[i] && seg_keep[i ^ 1];
    end
  end
  wire wide = cmd_instr_i.key_width > `DTS_SEG_PAIR_KEY;
  dts_pkg::dts_instr_s clipped;
  always_comb begin
    clipped = cmd_instr_i;
    if (dual_thread_mode_i) begin
      clipped.sb_mask = cmd_instr_i.sb_mask & sb_keep;
      clipped.seg_mask = cmd_instr_i.seg_mask & (wide ? seg_pair : seg_keep);
    end
  end

  wire bad = !dual_thread_mode_i && dup;
  wire [1:0] port_vec = (dual_thread_mode_i && cmd_port_i) ? 2'b10 : 2'b01;
  wire taken = |(valid_reg & link.req_ready);

  // one instruction in flight at a time
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= dts_pkg::DTS_H_IDLE;
      instr_reg <= '0;
      valid_reg <= 2'b00;
      cmd_ready_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      reject_reg <= 1'b0;
      case (state_reg)
        dts_pkg::DTS_H_IDLE: begin
          cmd_ready_reg <= 1'b1;
          if (cmd_valid_i && cmd_ready_reg) begin
            if (bad) begin
              reject_reg <= 1'b1;
            end else begin
              instr_reg <= clipped;
              valid_reg <= port_vec;
              cmd_ready_reg <= 1'b0;
              state_reg <= dts_pkg::DTS_H_SEND;
            end
          end
        end
        dts_pkg::DTS_H_SEND: begin
          if (taken) begin
            valid_reg <= 2'b00;
            cmd_ready_reg <= 1'b1;
            state_reg <= dts_pkg::DTS_H_IDLE;
          end
        end
        default: begin
          valid_reg <= 2'b00;
          state_reg <= dts_pkg::DTS_H_IDLE;
        end
      endcase
    end
  end

  assign link.req_valid = valid_reg;
  assign link.req_instr[0] = instr_reg;
  assign link.req_instr[1] = instr_reg;
  assign cmd_ready_o = cmd_ready_reg;
  assign reject_o = reject_reg;
endmodule
`default_nettype wire

// ===== rtl/dts_if.sv
`timescale 1ns/1ps
`default_nettype none
// two host ports of compare instructions
interface dts_if;
  logic [1:0] req_valid;
  logic [1:0] req_ready;
  dts_pkg::dts_instr_s req_instr [2];
  modport dev(input req_valid, input req_instr, output req_ready);
  modport host(output req_valid, output req_instr, input req_ready);
endinterface
`default_nettype wire

// ===== rtl/dts_params.svh
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH
// queue steering field of the search profile index
`define DTS_QSEL_HI 6
`define DTS_QSEL_LO 5
`define DTS_QDEPTH 4
// reset bank boundaries: first index owned by thread 1
`define DTS_RST_PROF_SPLIT 7'h40
`define DTS_RST_SB_SPLIT 7'h20
`define DTS_RST_SEG_SPLIT 7'h20
`define DTS_RST_KB_SPLIT 2'h2
`define DTS_RST_CM_SPLIT 4'h8
// legal boundary ranges
`define DTS_PROF_SPLIT_MIN 7'h20
`define DTS_PROF_SPLIT_MAX 7'h60
`define DTS_SB_SPLIT_MIN 7'h02
`define DTS_SB_SPLIT_MAX 7'h3e
`define DTS_SEG_SPLIT_MIN 7'h01
`define DTS_SEG_SPLIT_MAX 7'h3f
`define DTS_KB_SPLIT_MIN 2'h1
`define DTS_CM_SPLIT_MIN 4'h1
// key widths that force pairing
`define DTS_SB_PAIR_KEY 10'h1e0
`define DTS_SEG_PAIR_KEY 10'h140
`endif

// ===== rtl/dts_pkg.sv
`default_nettype none
package dts_pkg;
  // one compare instruction as issued by the host
  typedef struct packed {
    logic [6:0] profile;
    logic [9:0] key_width;
    logic [2:0] n_srch;
    logic [3:0][5:0] part;
    logic [63:0] sb_mask;
    logic [63:0] seg_mask;
  } dts_instr_s;

  typedef enum logic [1:0] {
    DTS_H_IDLE = 2'b01,
    DTS_H_SEND = 2'b10
  } dts_host_state_e;
endpackage
`default_nettype wire

// ===== rtl/dts_queue.sv
`timescale 1ns/1ps
`default_nettype none
// small instruction fifo, depth a power of two
module dts_queue #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic push_i,
  input wire logic [W-1:0] push_data_i,
  input wire logic pop_i,
  output logic head_valid_o,
  output logic [W-1:0] head_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  wire do_push = push_i && (cnt_reg != ($clog2(DEPTH+1))'(DEPTH));
  wire do_pop = pop_i && (cnt_reg != '0);

  // storage and pointers
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data_i;
    end
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
      rd_ptr_reg <= rd_ptr_reg + AW'(do_pop);
      cnt_reg <= cnt_reg + ($clog2(DEPTH+1))'(do_push) - ($clog2(DEPTH+1))'(do_pop);
    end
  end

  // head view
  assign head_valid_o = (cnt_reg != '0);
  assign head_data_o = mem[rd_ptr_reg];
  assign count_o = cnt_reg;
endmodule
`default_nettype wire

// ===== verification/dts_sched_properties.sv
`timescale 1ns/1ps
`default_nettype none
// link and issue checks between host and device
module dts_sched_properties (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] req_valid,
  input wire logic [1:0] req_ready,
  input wire dts_pkg::dts_instr_s req_instr [2],
  input wire logic [1:0] iss_valid_o,
  input wire dts_pkg::dts_instr_s iss0_instr_o,
  input wire dts_pkg::dts_instr_s iss1_instr_o,
  input wire logic bank_err_o,
  input wire logic dual_mode_o,
  input wire logic [1:0] kb_split_o,
  input wire logic [3:0] cm_split_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // reset config seen on the cycle after a reset edge
  a_reset_config: assert property (@(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> dual_mode_o && kb_split_o == 2'h2 && cm_split_o == 4'h8)
    else $error("reset config wrong");
  a_valid_hold: assert property (req_valid[0] && !req_ready[0] |=>
    req_valid[0] && $stable(req_instr[0])) else $error("offer dropped");
  a_issue_latency: assert property (req_valid[0] && req_ready[0] |->
    ##[2:40] iss_valid_o != 2'b00) else $error("no issue after take");
  a_thread_group: assert property (iss_valid_o[1] |->
    dual_mode_o && iss1_instr_o.profile >= 7'h40) else $error("bad thread 1");
  a_thread_low: assert property (dual_mode_o && iss_valid_o[0] |->
    iss0_instr_o.profile < 7'h40) else $error("bad thread 0");
  a_single_issue: assert property (!dual_mode_o |-> !iss_valid_o[1])
    else $error("second issue in single mode");
  a_mask_disjoint: assert property (iss_valid_o == 2'b11 |->
    (iss0_instr_o.sb_mask & iss1_instr_o.sb_mask) == 64'h0 &&
    (iss0_instr_o.seg_mask & iss1_instr_o.seg_mask) == 64'h0)
    else $error("overlapping issue");
  a_sb_in_bank: assert property (dual_mode_o |->
    (!iss_valid_o[0] || iss0_instr_o.sb_mask[63:32] == 32'h0) &&
    (!iss_valid_o[1] || iss1_instr_o.sb_mask[31:0] == 32'h0)) else $error("superblock cross");
  a_seg_in_bank: assert property (dual_mode_o |->
    (!iss_valid_o[0] || iss0_instr_o.seg_mask[63:32] == 32'h0) &&
    (!iss_valid_o[1] || iss1_instr_o.seg_mask[31:0] == 32'h0)) else $error("segment cross");
  a_no_bank_err: assert property (!bank_err_o)
    else $error("bank error flagged");
  c_dual_issue: cover property (iss_valid_o == 2'b11);
  c_port1_take: cover property (req_valid[1] && req_ready[1]);
  c_single_issue: cover property (!dual_mode_o && iss_valid_o[0]);
endmodule
`default_nettype wire

// ===== verification/dual_thread_search_scheduler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_thread_search_scheduler_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cfg_load = 1'b0;
  logic dual = 1'b1;
  logic two = 1'b0;
  logic [6:0] prof_split = 7'h40;
  logic [6:0] sb_split = 7'h20;
  logic [6:0] seg_split = 7'h20;
  logic [1:0] kb = 2'h2;
  logic [3:0] cm = 4'h8;
  logic cmd_valid = 1'b0;
  logic cmd_port = 1'b0;
  dts_pkg::dts_instr_s cmd_instr = '0;
  logic cmd_ready_o, reject_o, bank_err_o, cfg_err_o, dual_mode_o;
  logic [1:0] iss_valid_o, kb_split_o;
  logic [3:0] cm_split_o;
  dts_pkg::dts_instr_s iss0_instr_o, iss1_instr_o;
  dts_pkg::dts_instr_s sent_q [$];
  logic [31:0] seed = 32'h7d85;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_rej = 0;
  dts_if link();
  dts_device u_dts_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .cfg_load_i(cfg_load), .cfg_dual_i(dual), .cfg_two_port_i(two),
    .cfg_prof_split_i(prof_split), .cfg_sb_split_i(sb_split), .cfg_seg_split_i(seg_split),
    .cfg_kb_split_i(kb), .cfg_cm_split_i(cm), .iss_valid_o(iss_valid_o),
    .iss0_instr_o(iss0_instr_o), .iss1_instr_o(iss1_instr_o), .bank_err_o(bank_err_o),
    .cfg_err_o(cfg_err_o), .dual_mode_o(dual_mode_o), .kb_split_o(kb_split_o),
    .cm_split_o(cm_split_o));
  dts_host u_dts_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .dual_thread_mode_i(dual), .prof_split_i(prof_split), .sb_split_i(sb_split),
    .seg_split_i(seg_split), .cmd_valid_i(cmd_valid), .cmd_port_i(cmd_port),
    .cmd_instr_i(cmd_instr), .cmd_ready_o(cmd_ready_o), .reject_o(reject_o));
  dts_sched_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_instr(link.req_instr),
    .iss_valid_o(iss_valid_o), .iss0_instr_o(iss0_instr_o), .iss1_instr_o(iss1_instr_o),
    .bank_err_o(bank_err_o), .dual_mode_o(dual_mode_o), .kb_split_o(kb_split_o),
    .cm_split_o(cm_split_o));
  // clock, 4 ns period
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected thread of a profile
  function automatic logic exp_thread(input logic [6:0] prof);
    return dual && (prof >= prof_split);
  endfunction
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // match an issued instruction against what was sent
  task automatic chk_issue(input dts_pkg::dts_instr_s ins, input logic th);
    int idx;
    idx = -1;
    foreach (sent_q[i]) begin
      if (idx < 0 && sent_q[i].profile === ins.profile && sent_q[i].part === ins.part &&
          sent_q[i].key_width === ins.key_width) begin
        idx = i;
      end
    end
    cmp_vec({31'h0, idx >= 0}, 32'h1, "issued instr known");
    if (idx >= 0) begin
      sent_q.delete(idx);
    end
    cmp_vec({31'h0, th}, {31'h0, exp_thread(ins.profile)}, "thread");
  endtask
  // issue and reject monitor, settled at falling edge
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      if (iss_valid_o[0] === 1'b1) chk_issue(iss0_instr_o, 1'b0);
      if (iss_valid_o[1] === 1'b1) chk_issue(iss1_instr_o, 1'b1);
      if (reject_o === 1'b1) n_rej++;
    end
  end
  task automatic wait_cyc(input logic cond_ok, input int lim);
    if (!cond_ok && lim == 0) begin
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  // one user command, random or with duplicate partitions
  task automatic send(input logic dup);
    int lim;
    // let one edge pass after the previous strobe drop
    @(negedge clk_i);
    seed = lfsr(seed);
    cmd_instr.profile = seed[6:0];
    cmd_instr.key_width = seed[9] ? 10'h1e0 : (seed[8] ? 10'h140 : 10'h0a0);
    cmd_instr.n_srch = dup ? 3'h2 : {1'b0, seed[11:10]} + 3'h1;
    for (int i = 0; i < 4; i++) cmd_instr.part[i] = {seed[15:12], i[1:0]};
    if (dup) cmd_instr.part[1] = cmd_instr.part[0];
    cmd_instr.sb_mask = {lfsr(seed), seed};
    cmd_instr.seg_mask = {seed, lfsr(seed)};
    cmd_port = dual && two && seed[16];
    if (!dup) sent_q.push_back(cmd_instr);
    cmd_valid = 1'b1;
    lim = 200;
    while (cmd_ready_o !== 1'b1 && lim > 0) begin
      @(negedge clk_i);
      lim--;
    end
    wait_cyc(cmd_ready_o === 1'b1, lim);
    @(negedge clk_i);
    cmd_valid = 1'b0;
  endtask
  task automatic drain();
    int lim;
    lim = 400;
    while (sent_q.size() != 0 && lim > 0) begin
      @(negedge clk_i);
      lim--;
    end
    wait_cyc(sent_q.size() == 0, lim);
  endtask
  // configuration load, illegal values must be refused
  task automatic cfg(input logic d, input logic t, input logic [1:0] k, input logic [3:0] c);
    logic bad, seen;
    logic [1:0] k_old;
    logic [3:0] c_old;
    bad = (k == 2'h0) || (c == 4'h0);
    k_old = kb_split_o;
    c_old = cm_split_o;
    seen = 1'b0;
    @(negedge clk_i);
    {dual, two, kb, cm} = {d, t, k, c};
    cfg_load = 1'b1;
    @(negedge clk_i);
    cfg_load = 1'b0;
    // error pulse stands in the cycle right after the load edge
    seen = (cfg_err_o === 1'b1);
    repeat (3) begin
      @(negedge clk_i);
      seen = seen | (cfg_err_o === 1'b1);
    end
    cmp_vec({31'h0, seen}, {31'h0, bad}, "cfg err");
    cmp_vec({30'h0, kb_split_o}, {30'h0, bad ? k_old : k}, "kb split");
    cmp_vec({28'h0, cm_split_o}, {28'h0, bad ? c_old : c}, "cm split");
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    cmp_vec({31'h0, dual_mode_o}, 32'h1, "reset mode");
    cmp_vec({30'h0, kb_split_o}, 32'h2, "reset kb");
    cmp_vec({31'h0, link.req_ready[1]}, 32'h0, "port 1 closed");
    repeat (24) send(1'b0);
    drain();
    cfg(1'b1, 1'b0, 2'h0, 4'h4);
    cfg(1'b1, 1'b0, 2'h1, 4'h1);
    cfg(1'b1, 1'b0, 2'h2, 4'h0);
    cfg(1'b1, 1'b0, 2'h3, 4'hf);
    cfg(1'b1, 1'b1, 2'h2, 4'h8);
    cmp_vec({31'h0, link.req_ready[1]}, 32'h1, "port 1 open");
    repeat (24) send(1'b0);
    drain();
    cfg(1'b0, 1'b0, 2'h2, 4'h8);
    cmp_vec({31'h0, dual_mode_o}, 32'h0, "single mode");
    repeat (12) send(1'b0);
    send(1'b1);
    drain();
    repeat (4) @(negedge clk_i);
    cmp_vec(n_rej, 32'h1, "rejects");
    end_sim();
  end
endmodule
`default_nettype wire
